//--- src/cptb_pkg.sv
// package for the six programmable transmit/receive message buffers
// ================================================================
package cptb_pkg;

    // ================================================================
    // sizes and address map
    localparam int          CPTB_NBUF        = 6;
    localparam logic [11:0] CPTB_BUF_STRIDE  = 12'h0040;
    localparam logic [11:0] CPTB_GLOBAL_BASE = 12'h0180;
    localparam logic [3:0]  CPTB_IDX_CTL     = 4'h0;
    localparam logic [3:0]  CPTB_IDX_IDH     = 4'h1;
    localparam logic [3:0]  CPTB_IDX_IDL     = 4'h2;
    localparam logic [3:0]  CPTB_IDX_EIDH    = 4'h3;
    localparam logic [3:0]  CPTB_IDX_EIDL    = 4'h4;
    localparam logic [3:0]  CPTB_IDX_DLC     = 4'h5;
    localparam logic [3:0]  CPTB_IDX_DATA0   = 4'h6;
    localparam logic [3:0]  CPTB_IDX_DATA7   = 4'hD;
    localparam logic [3:0]  CPTB_IDX_DIRSEL  = 4'h0;
    localparam logic [3:0]  CPTB_IDX_MODE    = 4'h1;

    // ================================================================
    // field positions
    localparam int CPTB_RX_FULL_BIT   = 7;
    localparam int CPTB_RX_ALL_BIT    = 6;
    localparam int CPTB_TX_REQ_BIT    = 3;
    localparam int CPTB_TX_AUTO_BIT   = 2;
    localparam int CPTB_IDL_EXT_BIT   = 3;
    localparam int CPTB_DLC_RTR_BIT   = 6;
    localparam int CPTB_DIR_LSB       = 2;

    // ================================================================
    // reset values and modes
    localparam logic [1:0] CPTB_MODE_LEGACY = 2'h0;
    localparam logic [1:0] CPTB_MODE_RST    = 2'h0;
    localparam logic [5:0] CPTB_DIR_RST     = 6'h00;
    localparam logic [3:0] CPTB_DLC_MAX     = 4'h8;

    typedef enum logic [0:0] {
        CPTB_TX_IDLE = 1'b0,
        CPTB_TX_BUSY = 1'b1
    } cptb_txst_t;

    // ================================================================
    // carriers
    typedef struct packed {
        logic [28:0] id;
        logic        ext;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cptb_frame_t;

    typedef struct packed {
        logic        valid;
        logic        frame_ok;
        logic        filter_pass;
        logic [4:0]  hit;
        cptb_frame_t frame;
    } cptb_rx_t;

    typedef struct packed {
        logic done;
        logic arb_lost;
        logic bus_error;
        logic abort_ack;
    } cptb_txstat_t;

    typedef struct packed {
        logic        start;
        logic        busy;
        logic        abort;
        logic [2:0]  buf_num;
        cptb_frame_t frame;
    } cptb_launch_t;

    typedef struct packed {
        logic        full;
        logic        accept_all;
        logic [4:0]  hit;
        logic        done;
        logic        aborted;
        logic        arb_lost;
        logic        bus_error;
        logic        req;
        logic        auto_reply;
        logic [1:0]  prio;
        cptb_frame_t frame;
    } cptb_buf_t;

    typedef struct packed {
        cptb_buf_t [CPTB_NBUF-1:0] bufs;
        logic [CPTB_NBUF-1:0]      dir;
        logic [1:0]                mode;
        cptb_txst_t                st;
        logic [2:0]                cur;
        cptb_launch_t              launch;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
    } cptb_state_t;

endpackage

//--- src/cptb_buffers.sv
// six programmable transmit/receive message buffers with APB registers
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module cptb_buffers (
    // clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  NRST,
    // APB slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [11:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic [31:0]                PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // protocol engine
    input  wire cptb_pkg::cptb_rx_t     RX_EVT,
    input  wire cptb_pkg::cptb_txstat_t TX_STAT,
    output cptb_pkg::cptb_launch_t      TX_LAUNCH
);
    import cptb_pkg::*;

    cptb_state_t s;
    cptb_state_t next_s;

    // ================================================================
    // register read view of one buffer
    function automatic logic [8:0] rd_byte(input cptb_buf_t b, input logic tx,
                                           input logic [3:0] idx);
        logic [8:0] r;
        logic       srr;
        r   = 9'h000;
        srr = b.frame.ext | b.frame.rtr;
        if (idx == CPTB_IDX_CTL) begin
            if (tx) begin
                r = {1'b1, b.done, b.aborted, b.arb_lost, b.bus_error,
                     b.req, b.auto_reply, b.prio};
            end else begin
                r = {1'b1, b.full, b.accept_all, b.frame.rtr, b.hit};
            end
        end else if (idx == CPTB_IDX_IDH) begin
            r = {1'b1, b.frame.id[28:21]};
        end else if (idx == CPTB_IDX_IDL) begin
            // receive shows the frame type, transmit shows what software set
            r = {1'b1, b.frame.id[20:18], srr & ~tx, b.frame.ext, 1'b0,
                 b.frame.id[17:16]};
        end else if (idx == CPTB_IDX_EIDH) begin
            r = {1'b1, b.frame.id[15:8]};
        end else if (idx == CPTB_IDX_EIDL) begin
            r = {1'b1, b.frame.id[7:0]};
        end else if (idx == CPTB_IDX_DLC) begin
            r = {1'b1, 1'b0, b.frame.rtr, 2'b00, b.frame.dlc};
        end else if (idx >= CPTB_IDX_DATA0 && idx <= CPTB_IDX_DATA7) begin
            r = {1'b1, b.frame.data[8*(idx-CPTB_IDX_DATA0) +: 8]};
        end
        return r;
    endfunction

    // ================================================================
    // next-state logic
    always_comb begin
        logic             acc;
        logic             is_glob;
        logic             is_buf;
        logic [2:0]       bi;
        logic [3:0]       idx;
        logic [8:0]       rb;
        logic [7:0]       w;
        logic             wr;
        logic             used;
        logic             found;
        logic [1:0]       best;
        logic [2:0]       pick;
        logic             stored;
        logic             in_flight;
        cptb_frame_t      f;
        next_s    = s;
        acc       = PSEL && PENABLE;
        bi        = PADDR[8:6];
        idx       = PADDR[5:2];
        is_glob   = PADDR[11:6] == CPTB_GLOBAL_BASE[11:6];
        is_buf    = PADDR[11:9] == 3'h0 && int'(bi) < CPTB_NBUF;
        rb        = 9'h000;
        w         = PWDATA[7:0];
        wr        = acc && s.pready && PWRITE && PSTRB[0] && !s.pslverr;
        used      = s.mode != CPTB_MODE_LEGACY;
        found     = 1'b0;
        best      = 2'b00;
        pick      = 3'h0;
        stored    = 1'b0;
        in_flight = 1'b0;
        f         = '0;

        next_s.launch.start = 1'b0;
        next_s.pready       = 1'b0;
        next_s.pslverr      = 1'b0;

        // ============================================================
        // APB: one wait state, data and error ready with pready
        if (is_glob) begin
            if (idx == CPTB_IDX_DIRSEL) begin
                rb = {1'b1, s.dir, 2'b00};
            end else if (idx == CPTB_IDX_MODE) begin
                rb = {1'b1, 6'h00, s.mode};
            end
        end else if (is_buf) begin
            rb = rd_byte(s.bufs[bi], s.dir[bi], idx);
            // legacy mode hides the buffers: reads zero, writes dropped
            if (!used) begin
                rb = {rb[8], 8'h00};
            end
        end
        if (acc && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !rb[8];
            next_s.prdata  = {24'h00_0000, rb[7:0]};
        end

        if (wr && is_glob) begin
            if (idx == CPTB_IDX_DIRSEL) begin
                next_s.dir = w[7:CPTB_DIR_LSB];
            end else if (idx == CPTB_IDX_MODE) begin
                next_s.mode = w[1:0];
            end
        end else if (wr && is_buf && used && rb[8]) begin
            in_flight = s.st == CPTB_TX_BUSY && s.cur == bi;
            if (!s.dir[bi]) begin
                if (idx == CPTB_IDX_CTL) begin
                    next_s.bufs[bi].full       = w[CPTB_RX_FULL_BIT];
                    next_s.bufs[bi].accept_all = w[CPTB_RX_ALL_BIT];
                end
            end else if (s.bufs[bi].req || in_flight) begin
                // locked buffer: only clearing the request is honoured
                if (idx == CPTB_IDX_CTL && !w[CPTB_TX_REQ_BIT]) begin
                    if (in_flight) begin
                        next_s.launch.abort = 1'b1;
                    end else begin
                        next_s.bufs[bi].req     = 1'b0;
                        next_s.bufs[bi].aborted = 1'b1;
                    end
                end
            end else if (idx == CPTB_IDX_CTL) begin
                next_s.bufs[bi].req        = w[CPTB_TX_REQ_BIT];
                next_s.bufs[bi].auto_reply = w[CPTB_TX_AUTO_BIT];
                next_s.bufs[bi].prio       = w[1:0];
                if (w[CPTB_TX_REQ_BIT]) begin
                    next_s.bufs[bi].done      = 1'b0;
                    next_s.bufs[bi].aborted   = 1'b0;
                    next_s.bufs[bi].arb_lost  = 1'b0;
                    next_s.bufs[bi].bus_error = 1'b0;
                end
            end else if (idx == CPTB_IDX_IDH) begin
                next_s.bufs[bi].frame.id[28:21] = w;
            end else if (idx == CPTB_IDX_IDL) begin
                next_s.bufs[bi].frame.id[20:18] = w[7:5];
                next_s.bufs[bi].frame.ext       = w[CPTB_IDL_EXT_BIT];
                next_s.bufs[bi].frame.id[17:16] = w[1:0];
            end else if (idx == CPTB_IDX_EIDH) begin
                next_s.bufs[bi].frame.id[15:8] = w;
            end else if (idx == CPTB_IDX_EIDL) begin
                next_s.bufs[bi].frame.id[7:0] = w;
            end else if (idx == CPTB_IDX_DLC) begin
                // reserved codes 9..15 are stored as written and sent unchanged
                next_s.bufs[bi].frame.rtr = w[CPTB_DLC_RTR_BIT];
                next_s.bufs[bi].frame.dlc = w[3:0];
            end else begin
                next_s.bufs[bi].frame.data[8*(idx-CPTB_IDX_DATA0) +: 8] = w;
            end
        end

        // ============================================================
        // transmit: completion of the frame in flight
        if (s.st == CPTB_TX_BUSY) begin
            if (TX_STAT.done) begin
                next_s.bufs[s.cur].done = 1'b1;
                next_s.bufs[s.cur].req  = 1'b0;
            end else if (TX_STAT.abort_ack) begin
                next_s.bufs[s.cur].aborted = 1'b1;
                next_s.bufs[s.cur].req     = 1'b0;
            end else if (TX_STAT.arb_lost) begin
                next_s.bufs[s.cur].arb_lost = 1'b1;
            end else if (TX_STAT.bus_error) begin
                next_s.bufs[s.cur].bus_error = 1'b1;
            end
            // lost arbitration or bus error leaves the request set for a retry
            if (TX_STAT.done || TX_STAT.abort_ack || TX_STAT.arb_lost ||
                TX_STAT.bus_error) begin
                next_s.st           = CPTB_TX_IDLE;
                next_s.launch.busy  = 1'b0;
                next_s.launch.abort = 1'b0;
            end
        end

        // ============================================================
        // receive: store into the lowest free eligible buffer
        if (RX_EVT.valid && used) begin
            for (int i = 0; i < CPTB_NBUF; i++) begin
                if (!stored && !s.dir[i] && !next_s.bufs[i].full &&
                    (s.bufs[i].accept_all ||
                     (RX_EVT.frame_ok && RX_EVT.filter_pass))) begin
                    stored                 = 1'b1;
                    next_s.bufs[i].frame   = RX_EVT.frame;
                    next_s.bufs[i].hit     = RX_EVT.hit;
                    next_s.bufs[i].full    = 1'b1;
                end
                // automatic answer to a matching remote request
                if (s.dir[i] && s.bufs[i].auto_reply && !next_s.bufs[i].req &&
                    RX_EVT.frame.rtr && RX_EVT.frame_ok && RX_EVT.filter_pass &&
                    RX_EVT.frame.ext == s.bufs[i].frame.ext &&
                    RX_EVT.frame.id[28:18] == s.bufs[i].frame.id[28:18] &&
                    (!s.bufs[i].frame.ext ||
                     RX_EVT.frame.id[17:0] == s.bufs[i].frame.id[17:0])) begin
                    next_s.bufs[i].req       = 1'b1;
                    // a completion landing in this very cycle keeps its flag: set wins
                    next_s.bufs[i].done      = next_s.bufs[i].done & ~s.bufs[i].done;
                    next_s.bufs[i].aborted   = next_s.bufs[i].aborted & ~s.bufs[i].aborted;
                    next_s.bufs[i].arb_lost  = next_s.bufs[i].arb_lost & ~s.bufs[i].arb_lost;
                    next_s.bufs[i].bus_error = next_s.bufs[i].bus_error & ~s.bufs[i].bus_error;
                end
            end
        end

        // ============================================================
        // transmit: pick the next buffer, ties go to the higher number
        if (next_s.st == CPTB_TX_IDLE && s.st == CPTB_TX_IDLE && used) begin
            for (int i = 0; i < CPTB_NBUF; i++) begin
                if (next_s.dir[i] && next_s.bufs[i].req &&
                    (!found || next_s.bufs[i].prio >= best)) begin
                    found = 1'b1;
                    best  = next_s.bufs[i].prio;
                    pick  = 3'(i);
                end
            end
            if (found) begin
                f = next_s.bufs[pick].frame;
                if (!f.ext) begin
                    f.id[17:0] = 18'h0_0000;
                end
                // priority orders only; a standard frame goes out with identifier bits 17..0 cleared
                next_s.st             = CPTB_TX_BUSY;
                next_s.cur            = pick;
                next_s.launch.start   = 1'b1;
                next_s.launch.busy    = 1'b1;
                next_s.launch.abort   = 1'b0;
                next_s.launch.buf_num = pick;
                next_s.launch.frame   = f;
            end
        end
    end

    // ================================================================
    // state register
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            s      <= '0;
            s.dir  <= CPTB_DIR_RST;
            s.mode <= CPTB_MODE_RST;
            s.st   <= CPTB_TX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA    = s.prdata;
    assign PREADY    = s.pready;
    assign PSLVERR   = s.pslverr;
    assign TX_LAUNCH = s.launch;

endmodule

//--- verification/cptb_buffers_checker.sv
// concurrent checks on the ports of the message buffer block
`timescale 1ns/1ps
module cptb_buffers_checker (
    // clock and reset
    input wire logic                   CLK_SYS,
    input wire logic                   NRST,
    // register bus
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic [31:0]            PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    // protocol engine
    input wire cptb_pkg::cptb_txstat_t TX_STAT,
    input wire cptb_pkg::cptb_launch_t TX_LAUNCH
);
    import cptb_pkg::*;
    wire stat_any = |TX_STAT;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // ================================================================
    // bus handshake
    wait_state_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready missing one cycle into access");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
    err_with_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error outside a transfer");
    rdata_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    // ================================================================
    // launch side
    start_pulse_a: assert property (TX_LAUNCH.start |-> TX_LAUNCH.busy ##1 !TX_LAUNCH.start)
        else $error("start not a single pulse with busy");
    start_gap_a: assert property (TX_LAUNCH.start |-> !$past(TX_LAUNCH.busy))
        else $error("start while previous launch busy");
    busy_ends_a: assert property (TX_LAUNCH.busy && stat_any |=> !TX_LAUNCH.busy)
        else $error("busy held after status pulse");
    frame_hold_a: assert property (TX_LAUNCH.busy && !TX_LAUNCH.start |->
        $stable(TX_LAUNCH.frame) && $stable(TX_LAUNCH.buf_num)) else $error("frame moved");
    std_id_a: assert property (TX_LAUNCH.busy && !TX_LAUNCH.frame.ext |->
        TX_LAUNCH.frame.id[17:0] == 18'h0_0000) else $error("standard frame low id set");
    abort_busy_a: assert property (TX_LAUNCH.abort |-> TX_LAUNCH.busy)
        else $error("abort without launch");
    cover property (TX_LAUNCH.start);
    cover property (TX_LAUNCH.abort && TX_STAT.abort_ack);
    cover property (PSLVERR);
endmodule
bind cptb_buffers cptb_buffers_checker chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_STAT(TX_STAT), .TX_LAUNCH(TX_LAUNCH));

//--- verification/cptb_engine_model.sv
// protocol engine stand-in: answers launches and injects received frames
`timescale 1ns/1ps
module cptb_engine_model (
    // clock and reset
    input wire logic                   CLK_SYS,
    input wire logic                   NRST,
    // block side
    input wire cptb_pkg::cptb_launch_t TX_LAUNCH,
    output cptb_pkg::cptb_rx_t         RX_EVT,
    output cptb_pkg::cptb_txstat_t     TX_STAT
);
    import cptb_pkg::*;
    int           lat  = 4;
    int           resp = 0;
    int           cnt  = 0;
    logic         live = 1'b0;
    cptb_txstat_t s;
    logic [2:0]   starts[$];
    cptb_frame_t  frames[$];
    initial begin
        RX_EVT  = '0;
        TX_STAT = '0;
    end
    // one status pulse per launch; an abort is answered at once, so never late
    always @(posedge CLK_SYS or negedge NRST) begin
        s = '0;
        if (!NRST) begin
            live <= 1'b0;
        end else if (TX_LAUNCH.start) begin
            starts.push_back(TX_LAUNCH.buf_num);
            frames.push_back(TX_LAUNCH.frame);
            live <= 1'b1;
            cnt  <= lat;
        end else if (live && TX_LAUNCH.abort) begin
            s.abort_ack = 1'b1;
            live <= 1'b0;
        end else if (live && cnt <= 1) begin
            s.done      = (resp == 0);
            s.arb_lost  = (resp == 1);
            s.bus_error = (resp == 2);
            live <= 1'b0;
        end else if (live) begin
            cnt <= cnt - 1;
        end
        TX_STAT <= s;
    end
    // payload is scrambled outside the valid cycle so stale fields never pass
    task automatic send_rx(input cptb_rx_t e);
        cptb_rx_t idle;
        idle       = ~e;
        idle.valid = 1'b0;
        @(posedge CLK_SYS);
        RX_EVT <= e;
        @(posedge CLK_SYS);
        RX_EVT <= idle;
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the programmable message buffers
`timescale 1ns/1ps
module testbench;
    import cptb_pkg::*;
    logic         CLK_SYS = 1'b0;
    logic         NRST    = 1'b0;
    logic         PSEL    = 1'b0;
    logic         PENABLE = 1'b0;
    logic         PWRITE  = 1'b0;
    logic [11:0]  PADDR   = 12'h000;
    logic [31:0]  PWDATA  = 32'h0000_0000;
    logic [3:0]   PSTRB   = 4'hF;
    logic [31:0]  PRDATA;
    logic         PREADY;
    logic         PSLVERR;
    cptb_rx_t     RX_EVT;
    cptb_txstat_t TX_STAT;
    cptb_launch_t TX_LAUNCH;
    logic [7:0]   rdv;
    logic         last_err;
    cptb_rx_t     ev;
    int           miscompares = 0;
    int           num_checks  = 0;
    localparam logic [11:0] g_dir  = CPTB_GLOBAL_BASE;
    localparam logic [11:0] g_mode = CPTB_GLOBAL_BASE + 12'h004;

    always #2.5 CLK_SYS = ~CLK_SYS;

    cptb_buffers dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_EVT(RX_EVT), .TX_STAT(TX_STAT),
        .TX_LAUNCH(TX_LAUNCH));
    cptb_engine_model eng (.CLK_SYS(CLK_SYS), .NRST(NRST), .TX_LAUNCH(TX_LAUNCH),
        .RX_EVT(RX_EVT), .TX_STAT(TX_STAT));

    // ================================================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge CLK_SYS);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= a;
        PWDATA <= 32'(d);
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        check("ready", 32'h1, 32'(PREADY));
        rdv      = PRDATA[7:0];
        last_err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(nm, 32'(e), 32'(rdv));
    endtask
    function automatic logic [11:0] ra(input int b, input logic [3:0] i);
        return 12'(b) * CPTB_BUF_STRIDE + 12'({i, 2'b00});
    endfunction
    task automatic mk(input logic ok, input logic [4:0] h, input logic [28:0] id,
                      input logic ext, input logic rtr);
        ev             = '0;
        ev.valid       = 1'b1;
        ev.frame_ok    = ok;
        ev.filter_pass = ok;
        ev.hit         = h;
        ev.frame.id    = id;
        ev.frame.ext   = ext;
        ev.frame.rtr   = rtr;
    endtask
    task automatic wait_starts(input int k);
        int n = 0;
        while (eng.starts.size() < k && n < 600) begin
            @(posedge CLK_SYS);
            n++;
        end
        check("launch count", 32'(k), 32'(eng.starts.size()));
    endtask
    task automatic idle_wait;
        int n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (TX_LAUNCH.busy !== 1'b0 && n < 400);
    endtask

    // ================================================================
    // scenarios
    task automatic s_mode0;
        rd("dir reset", g_dir, 8'h00);
        rd("mode reset", g_mode, 8'h00);
        wr(ra(0, CPTB_IDX_CTL), 8'h40);
        mk(1'b1, 5'h01, 29'h0000_0000, 1'b0, 1'b0);
        eng.send_rx(ev);
        wr(g_mode, 8'h01);
        rd("legacy unused", ra(0, CPTB_IDX_CTL), 8'h00);
        apb(1'b0, 12'h1C0, 8'h00);
        check("unmapped error", 32'h1, 32'(last_err));
    endtask
    task automatic s_rx;
        logic [28:0] xid;
        xid = 29'h1ABC_DEF5;
        mk(1'b1, 5'h0F, xid, 1'b1, 1'b0);
        ev.frame.dlc  = 4'h8;
        ev.frame.data = 64'h0123_4567_89AB_CDEF;
        eng.send_rx(ev);
        rd("rx0 ctl", ra(0, CPTB_IDX_CTL), 8'h8F);
        rd("rx0 idh", ra(0, CPTB_IDX_IDH), xid[28:21]);
        rd("rx0 idl", ra(0, CPTB_IDX_IDL), {xid[20:18], 3'b110, xid[17:16]});
        rd("rx0 eidh", ra(0, CPTB_IDX_EIDH), xid[15:8]);
        rd("rx0 dlc", ra(0, CPTB_IDX_DLC), 8'h08);
        rd("rx0 data7", ra(0, CPTB_IDX_DATA7), 8'h01);
        mk(1'b1, 5'h00, {11'h5A3, 18'h0_0000}, 1'b0, 1'b1);
        eng.send_rx(ev);
        rd("rx0 kept", ra(0, CPTB_IDX_IDH), xid[28:21]);
        rd("rx1 ctl", ra(1, CPTB_IDX_CTL), 8'hA0);
        rd("rx1 idl", ra(1, CPTB_IDX_IDL), 8'h70);
        mk(1'b0, 5'h03, 29'h0000_0001, 1'b1, 1'b0);
        eng.send_rx(ev);
        rd("filtered drop", ra(2, CPTB_IDX_CTL), 8'h00);
        wr(ra(2, CPTB_IDX_CTL), 8'h40);
        eng.send_rx(ev);
        rd("accept all", ra(2, CPTB_IDX_CTL), 8'hC3);
        wr(ra(0, CPTB_IDX_CTL), 8'h00);
        mk(1'b1, 5'h01, 29'h0000_0000, 1'b0, 1'b0);
        eng.send_rx(ev);
        rd("refill", ra(0, CPTB_IDX_CTL), 8'h81);
    endtask
    task automatic s_tx_order;
        wr(g_dir, 8'hE0);
        eng.lat = 30;
        wr(ra(5, CPTB_IDX_IDH), 8'hA5);
        wr(ra(5, CPTB_IDX_IDL), 8'hA3);
        wr(ra(5, CPTB_IDX_CTL), 8'h08);
        wait_starts(1);
        wr(ra(5, CPTB_IDX_IDH), 8'h00);
        rd("locked idh", ra(5, CPTB_IDX_IDH), 8'hA5);
        wr(ra(3, CPTB_IDX_CTL), 8'h0B);
        wr(ra(4, CPTB_IDX_CTL), 8'h0B);
        wait_starts(3);
        check("first id", 32'({8'hA5, 3'b101, 18'h0_0000}), 32'(eng.frames[0].id));
        check("tie goes high", 32'h4, 32'(eng.starts[1]));
        check("then lower", 32'h3, 32'(eng.starts[2]));
        idle_wait;
        rd("sent flags", ra(5, CPTB_IDX_CTL), 8'h80);
        rd("kept prio", ra(3, CPTB_IDX_CTL), 8'h83);
    endtask
    task automatic s_tx_faults;
        PSTRB <= 4'hE;
        wr(ra(4, CPTB_IDX_CTL), 8'h08);
        PSTRB <= 4'hF;
        rd("strobe off", ra(4, CPTB_IDX_CTL), 8'h83);
        eng.resp = 1;
        eng.lat  = 2;
        wr(ra(4, CPTB_IDX_CTL), 8'h08);
        wait_starts(5);
        rd("arb lost", ra(4, CPTB_IDX_CTL), 8'h28);
        eng.resp = 2;
        wait_starts(8);
        rd("bus error", ra(4, CPTB_IDX_CTL), 8'h38);
        eng.lat = 200;
        wait_starts(9);
        wr(ra(4, CPTB_IDX_CTL), 8'h00);
        idle_wait;
        rd("aborted", ra(4, CPTB_IDX_CTL), 8'h70);
        eng.resp = 0;
        eng.lat  = 50;
        wr(ra(4, CPTB_IDX_CTL), 8'h08);
        rd("flags cleared", ra(4, CPTB_IDX_CTL), 8'h08);
        wr(ra(5, CPTB_IDX_CTL), 8'h08);
        wr(ra(5, CPTB_IDX_CTL), 8'h00);
        rd("queued abort", ra(5, CPTB_IDX_CTL), 8'h40);
        idle_wait;
        rd("done again", ra(4, CPTB_IDX_CTL), 8'h80);
    endtask
    task automatic s_auto;
        wr(ra(3, CPTB_IDX_IDH), 8'h5A);
        wr(ra(3, CPTB_IDX_IDL), 8'h60);
        wr(ra(3, CPTB_IDX_CTL), 8'h04);
        eng.lat = 2;
        mk(1'b1, 5'h02, {8'h5A, 3'b011, 18'h0_0000}, 1'b0, 1'b1);
        eng.send_rx(ev);
        wait_starts(11);
        check("reply buffer", 32'h3, 32'(eng.starts[10]));
        check("reply id", 32'({8'h5A, 3'b011, 18'h0_0000}), 32'(eng.frames[10].id));
        idle_wait;
        wr(ra(3, CPTB_IDX_CTL), 8'h00);
        eng.send_rx(ev);
        // launch follows a request within one cycle, so eight cycles suffice
        repeat (8) @(posedge CLK_SYS);
        check("no reply", 32'd11, 32'(eng.starts.size()));
        wr(g_mode, 8'h00);
        rd("legacy hidden", ra(0, CPTB_IDX_CTL), 8'h00);
        wr(g_mode, 8'h02);
        rd("mode two", g_mode, 8'h02);
        rd("mode two used", ra(0, CPTB_IDX_CTL), 8'h81);
    endtask

    // ================================================================
    // sequence, watchdog and verdict
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK_SYS);
        NRST <= 1'b1;
        s_mode0;
        s_rx;
        s_tx_order;
        s_tx_faults;
        s_auto;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        miscompares++;
        test_done;
    end
endmodule
